// ---- inc/fn_reset_pkg.sv ----
`default_nettype none
package fn_reset_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Wishbone port)
  // ----------------------------------------------------------------
  localparam int           ADR_W        = 8;         // Byte address width.
  localparam logic [7:0]   ADR_CTRL     = 8'h00;     // Command and initiate word.
  localparam logic [7:0]   ADR_STATUS   = 8'h04;     // Read-only status word.
  localparam logic [1:0]   MEM_REGION   = 2'h1;      // Bits 7:6 selecting the local memory.
  localparam int           MEM_WORDS    = 16;        // Software-visible local memory depth.
  localparam int           MEM_IDX_W    = 4;         // Index width of that memory.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_BUS_MASTER = 0;   // Lets the function issue non-posted requests.
  localparam int CTRL_DRIVER_UP  = 1;   // Driver has initialised the external side.
  localparam int CTRL_INTX       = 2;   // Legacy interrupt asserted by the function.
  localparam int CTRL_INITIATE   = 15;  // Write one to start the function reset.
  localparam int ST_PENDING      = 0;   // Transactions pending.
  localparam int ST_IN_PROGRESS  = 1;   // Internal scrub running.
  localparam int ST_EXPIRED      = 2;   // Time limit has run out.
  localparam int ST_READY        = 3;   // Function-specific initialisation done.
  localparam int ST_COUNT_LSB    = 8;   // Outstanding request count, bits 15:8.

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET       = 16'h0000;  // Command bits after any reset.
  localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;  // Scrub fill and idle data.
  localparam int          RESET_LIMIT_MS  = 100;       // Time allowed to finish the reset.
  localparam int          CLK_FREQ_KHZ    = 125_000;   // Core clock rate.
  localparam int          LIMIT_CYCLES_DEF = RESET_LIMIT_MS * CLK_FREQ_KHZ;  // Cycles in limit.
  localparam int          TIMER_W         = 24;        // Holds the limit count.

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_QUIESCE, ST_SCRUB, ST_WAIT_INIT} fsm_t;
  typedef enum logic {CPL_SUCCESS, CPL_RETRY} cpl_status_t;

  typedef struct packed {
    logic              cyc;   // Bus cycle.
    logic              stb;   // Strobe.
    logic              we;    // Write enable.
    logic [ADR_W-1:0]  adr;   // Byte address.
    logic [3:0]        sel;   // Byte lanes.
    logic [31:0]       dat;   // Write data.
  } wb_req_t;

  typedef struct packed {
    logic        ack;         // Single-cycle acknowledge.
    logic [31:0] dat;         // Read data.
  } wb_rsp_t;

  typedef struct packed {
    logic cfg_req;            // Configuration request arrives.
    logic rx_req;             // Other request arrives.
    logic rx_cpl;             // Completion arrives.
    logic np_issue;           // Function wants to issue a non-posted request.
  } link_in_t;

  typedef struct packed {
    logic        cfg_cpl;     // Configuration completion sent.
    cpl_status_t cfg_status;  // Its status.
    logic        credit;      // Flow-control credit returned for a dropped packet.
    logic        discard;     // Packet dropped silently.
    logic        deliver_req; // Request passed to the function.
    logic        deliver_cpl; // Completion passed to the function.
    logic        unexpected;  // Completion matched no outstanding request.
    logic        np_grant;    // Non-posted request allowed out.
    logic        deassert_intx; // Send the legacy interrupt deassert message.
  } link_out_t;

endpackage : fn_reset_pkg
`default_nettype wire

// ---- hdl/function_level_reset_unit.sv ----
// Overview of operation
// - Hide host-initialised appearance during and after reset.
// - Touch only this function's share of interface.
// - Leave no readable earlier state; never write host.
// - Clear software-readable local memory during reset.
// - End reset usable again after normal configuration.
// - Send initiating write's completion, then start reset.
// - Drop requests while the scrub runs, after returning credits.
// - Drop completions while the scrub runs, after returning credits.
// - Answer configuration with retry after limit, until ready.
// - After non-retry answer, never retry until next reset.
// - Forget outstanding non-posted requests; late completions stale.
// - Initiate bit starts reset; finish within 100 ms.
// - Pending bit reads zero when reset completes.
// - Deassert legacy interrupt in the cycle the scrub starts.
// - Never disturb link, physical or data-link state.
`default_nettype none
module function_level_reset_unit
#(
  parameter int LIMIT_CYCLES = fn_reset_pkg::LIMIT_CYCLES_DEF  // Reset time limit in cycles.
)
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    SRST,
  input  wire fn_reset_pkg::wb_req_t   WB_REQ,
  output var  fn_reset_pkg::wb_rsp_t   WB_RSP,
  input  wire fn_reset_pkg::link_in_t  LINK_IN,
  output var  fn_reset_pkg::link_out_t LINK_OUT,
  input  wire logic                    INIT_DONE,
  output logic                         FN_CORE_RESET,
  output logic                         EXT_HOST_ACTIVE
);
  import fn_reset_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fsm_t                                fsm;        // Sequencer state.
    logic                                in_prog;    // Scrub running.
    logic [TIMER_W-1:0]                  timer;      // Cycles since initiate.
    logic                                expired;    // Limit reached.
    logic                                ready;      // Initialisation finished.
    logic                                no_retry;   // A non-retry answer was sent.
    logic [15:0]                         cmd;        // Command bits.
    logic [7:0]                          pending;    // Outstanding non-posted count.
    logic [MEM_WORDS-1:0][31:0]          mem;        // Local memory seen by software.
    logic [MEM_IDX_W-1:0]                scrub_idx;  // Next word to clear.
    wb_rsp_t                             rsp;        // Bus answer.
    link_out_t                           lo;         // Link-side pulses.
  } state_t;

  state_t s;       // Registered state.
  state_t next_s;  // Next state.

  logic                 wb_req;      // A request waits for its acknowledge.
  logic                 wb_take;     // Edge at which the master samples acknowledge.
  logic                 ctrl_hit;    // Address hits the control word.
  logic                 mem_hit;     // Address hits the local memory.
  logic [MEM_IDX_W-1:0] mem_idx;     // Word within the local memory.
  logic                 start;       // Initiate written at acknowledge.
  logic [31:0]          ctrl_view;   // Control word as read.
  logic [31:0]          status_view; // Status word as read.
  logic [31:0]          wmask;       // Byte-lane mask from select.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // The write happens at the acknowledge edge, so the master's held request is the source.
  assign wb_req   = WB_REQ.cyc && WB_REQ.stb;
  assign wb_take  = wb_req && s.rsp.ack;
  assign ctrl_hit = (WB_REQ.adr == ADR_CTRL);
  assign mem_hit  = (WB_REQ.adr[7:6] == MEM_REGION);
  assign mem_idx  = WB_REQ.adr[MEM_IDX_W+1:2];
  // The completion (acknowledge) is already out when the sequencer leaves idle.
  assign start    = wb_take && WB_REQ.we && ctrl_hit && WB_REQ.sel[1]
                    && WB_REQ.dat[CTRL_INITIATE] && (s.fsm == ST_IDLE);

  // Expand the byte selects into a bit mask, one lane per loop step.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wmask[g*8 +: 8] = {8{WB_REQ.sel[g]}};
    end
  endgenerate

  // Control reads back without the self-clearing initiate bit.
  assign ctrl_view   = {16'h0000, s.cmd};
  assign status_view = {16'h0000, s.pending, 4'h0, s.ready, s.expired, s.in_prog,
                        (s.pending != 8'h00)};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process computes everything; pulses default low every cycle.
  always_comb
  begin
    next_s                 = s;
    next_s.lo              = '0;
    next_s.lo.cfg_status   = CPL_SUCCESS;
    next_s.rsp.ack         = wb_req && !s.rsp.ack;
    next_s.rsp.dat         = DATA_ZERO;

    // Read data is latched with the acknowledge; unmapped addresses read zero.
    if (wb_req && !s.rsp.ack && !WB_REQ.we)
    begin
      if (ctrl_hit)
        next_s.rsp.dat = ctrl_view;
      else if (WB_REQ.adr == ADR_STATUS)
        next_s.rsp.dat = status_view;
      else if (mem_hit)
        next_s.rsp.dat = s.mem[mem_idx];
    end

    // Writes land only outside the reset sequence; unmapped writes are ignored.
    if (wb_take && WB_REQ.we && (s.fsm == ST_IDLE))
    begin
      if (ctrl_hit)
        next_s.cmd = (s.cmd & ~wmask[15:0]) | (WB_REQ.dat[15:0] & wmask[15:0] & 16'h7FFF);
      else if (mem_hit)
        next_s.mem[mem_idx] = (s.mem[mem_idx] & ~wmask) | (WB_REQ.dat & wmask);
    end

    // Non-posted requests leave only with bus mastering on and no reset running.
    if (LINK_IN.np_issue && s.cmd[CTRL_BUS_MASTER] && !s.in_prog
        && (s.fsm == ST_IDLE) && (s.pending != 8'hFF))
    begin
      next_s.lo.np_grant = 1'b1;
      next_s.pending     = s.pending + 8'h01;
    end

    // Non-configuration traffic while scrubbing: return credits, drop quietly.
    if (s.in_prog)
    begin
      if (LINK_IN.rx_req || LINK_IN.rx_cpl)
      begin
        next_s.lo.credit  = 1'b1;
        next_s.lo.discard = 1'b1;
      end
    end
    else
    begin
      next_s.lo.deliver_req = LINK_IN.rx_req;
      if (LINK_IN.rx_cpl && (s.pending == 8'h00))
        next_s.lo.unexpected = 1'b1;
      else if (LINK_IN.rx_cpl)
      begin
        next_s.lo.deliver_cpl = 1'b1;
        next_s.pending        = next_s.pending - 8'h01;
      end
    end

    // Configuration answers: drop once the reset has begun and before the limit, retry after.
    // Quiesce counts as reset: a success sent there would be forgotten by the latch clear.
    if (LINK_IN.cfg_req)
    begin
      if (s.in_prog || (s.fsm == ST_QUIESCE) || ((s.fsm == ST_WAIT_INIT) && !s.expired))
      begin
        next_s.lo.credit  = 1'b1;
        next_s.lo.discard = 1'b1;
      end
      else if ((s.fsm == ST_WAIT_INIT) && !s.no_retry)
      begin
        next_s.lo.cfg_cpl    = 1'b1;
        next_s.lo.cfg_status = CPL_RETRY;
      end
      else
      begin
        next_s.lo.cfg_cpl = 1'b1;
        next_s.no_retry   = 1'b1;
      end
    end

    // Limit timer runs from initiate until the function is ready or the limit is reached.
    if ((s.fsm != ST_IDLE) && !s.expired)
    begin
      next_s.timer = s.timer + 1'b1;
      if (s.timer == TIMER_W'(LIMIT_CYCLES - 1))
        next_s.expired = 1'b1;
    end

    unique case (s.fsm)
      // Normal operation; only an initiate write leaves it.
      ST_IDLE:
      begin
        if (start)
        begin
          next_s.fsm     = ST_QUIESCE;
          next_s.timer   = '0;
          next_s.expired = 1'b0;
        end
      end
      // Withdraw a legacy interrupt at the edge that clears the command bits and starts the scrub.
      ST_QUIESCE:
      begin
        if (s.cmd[CTRL_INTX])
          next_s.lo.deassert_intx = 1'b1;
        next_s.cmd       = CMD_RESET;
        next_s.in_prog   = 1'b1;
        next_s.scrub_idx = '0;
        next_s.ready     = 1'b0;
        next_s.no_retry  = 1'b0;
        next_s.fsm       = ST_SCRUB;
      end
      // Clear one memory word per cycle and forget outstanding requests.
      ST_SCRUB:
      begin
        next_s.mem[s.scrub_idx] = DATA_ZERO;
        next_s.pending          = 8'h00;
        next_s.scrub_idx        = s.scrub_idx + 1'b1;
        if (s.scrub_idx == MEM_IDX_W'(MEM_WORDS - 1))
        begin
          next_s.in_prog = 1'b0;
          next_s.fsm     = ST_WAIT_INIT;
        end
      end
      // Wait for function-specific initialisation; then back to normal use.
      ST_WAIT_INIT:
      begin
        if (INIT_DONE)
        begin
          next_s.ready = 1'b1;
          next_s.fsm   = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset brings the whole function to its power-on state.
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      s         <= '0;
      s.fsm     <= ST_IDLE;
      s.cmd     <= CMD_RESET;
      s.ready   <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The core reset covers only this function's datapath; no link-layer reset exists here.
  assign FN_CORE_RESET   = s.in_prog;
  // External side shows this function's host-driven state only; other functions untouched.
  assign EXT_HOST_ACTIVE = s.cmd[CTRL_DRIVER_UP] && (s.fsm == ST_IDLE);
  assign WB_RSP          = s.rsp;
  assign LINK_OUT        = s.lo;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_after_ack;
    @(posedge SYS_CLK) disable iff (SRST)
    start |-> s.rsp.ack ##1 (s.fsm == ST_QUIESCE) ##1 s.in_prog;
  endproperty
  a_start_after_ack: assert property (p_start_after_ack)
    else $error("reset began before the initiating completion");

  property p_drop_req;
    @(posedge SYS_CLK) disable iff (SRST)
    (s.in_prog && LINK_IN.rx_req) |=> (LINK_OUT.credit && LINK_OUT.discard
                                        && !LINK_OUT.deliver_req);
  endproperty
  a_drop_req: assert property (p_drop_req)
    else $error("request during reset not dropped with credit");

  property p_drop_cpl;
    @(posedge SYS_CLK) disable iff (SRST)
    (s.in_prog && LINK_IN.rx_cpl) |=> (LINK_OUT.credit && !LINK_OUT.deliver_cpl
                                        && !LINK_OUT.unexpected);
  endproperty
  a_drop_cpl: assert property (p_drop_cpl)
    else $error("completion during reset not dropped with credit");

  property p_retry_after_limit;
    @(posedge SYS_CLK) disable iff (SRST)
    (LINK_IN.cfg_req && (s.fsm == ST_WAIT_INIT) && s.expired && !s.no_retry)
      |=> (LINK_OUT.cfg_cpl && (LINK_OUT.cfg_status == CPL_RETRY));
  endproperty
  a_retry_after_limit: assert property (p_retry_after_limit)
    else $error("no retry status after the time limit");

  property p_no_retry_after_success;
    @(posedge SYS_CLK) disable iff (SRST)
    (LINK_OUT.cfg_cpl && (LINK_OUT.cfg_status == CPL_SUCCESS))
      |=> !(LINK_OUT.cfg_cpl && (LINK_OUT.cfg_status == CPL_RETRY))[*8];
  endproperty
  a_no_retry_after_success: assert property (p_no_retry_after_success)
    else $error("retry status returned after a success");

  property p_scrub_clean;
    @(posedge SYS_CLK) disable iff (SRST)
    ((s.fsm == ST_WAIT_INIT) && ($past(s.fsm) == ST_SCRUB))
      |-> ((s.mem == '0) && (s.cmd == CMD_RESET));
  endproperty
  a_scrub_clean: assert property (p_scrub_clean)
    else $error("readable state survived the scrub");

  property p_pending_clear;
    @(posedge SYS_CLK) disable iff (SRST)
    $fell(s.in_prog) |-> ((status_view[ST_PENDING] == 1'b0) && !LINK_OUT.np_grant);
  endproperty
  a_pending_clear: assert property (p_pending_clear)
    else $error("pending bit set when the reset completed");

  property p_intx_first;
    @(posedge SYS_CLK) disable iff (SRST)
    ((s.fsm == ST_QUIESCE) && s.cmd[CTRL_INTX]) |=> (LINK_OUT.deassert_intx && s.in_prog);
  endproperty
  a_intx_first: assert property (p_intx_first)
    else $error("legacy interrupt not withdrawn at reset start");

  property p_hidden;
    @(posedge SYS_CLK) disable iff (SRST)
    s.in_prog |-> !EXT_HOST_ACTIVE;
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("external side looks host-initialised during reset");

  property p_finish_in_time;
    @(posedge SYS_CLK) disable iff (SRST)
    $rose(s.in_prog) |-> s.in_prog[*8] ##[8:20] !s.in_prog;
  endproperty
  a_finish_in_time: assert property (p_finish_in_time)
    else $error("scrub did not finish in its bounded time");

  property p_flag_states;
    @(posedge SYS_CLK) disable iff (SRST)
    s.in_prog |-> ((s.fsm == ST_SCRUB) && !s.expired || (s.fsm == ST_SCRUB));
  endproperty
  a_flag_states: assert property (p_flag_states)
    else $error("in-progress flag outside the scrub");

endmodule : function_level_reset_unit
`default_nettype wire

// ---- tb/link_partner.sv ----
`default_nettype none
module link_partner
(
  input  wire fn_reset_pkg::link_out_t link_out,  // Answers coming back from the function.
  input  wire logic                    sys_clk,   // Core clock shared with the function.
  output var  fn_reset_pkg::link_in_t  link_in,   // Packets handed to the function.
  output var  logic [7:0]              credits    // Credits handed back for dropped packets.
);
  timeunit 1ns;
  timeprecision 100ps;
  import fn_reset_pkg::*;

  // ------------------------------------------------------------------
  // Link side stimulus
  // ------------------------------------------------------------------

  // Nothing is in flight before the first packet is sent.
  initial
  begin
    link_in = '0;
    credits = 8'h00;
  end

  // Sends one packet for exactly one cycle, then collects the one-cycle answer.
  // The line drops after one cycle so that the function never counts a packet twice.
  task automatic fire(input link_in_t v, output link_out_t seen);
    @(posedge sys_clk);
    link_in <= v;
    @(posedge sys_clk);
    link_in <= '0;
    #1 seen = link_out;
    // A dropped packet only frees our buffer space once its credit comes back.
    if (seen.credit === 1'b1)
    begin
      credits = credits + 8'h01;
    end
  endtask : fire
endmodule : link_partner
`default_nettype wire

// ---- tb/tb_function_level_reset_unit.sv ----
`default_nettype none
module tb_function_level_reset_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import fn_reset_pkg::*;

  // ------------------------------------------------------------------
  // Constants and signals
  // ------------------------------------------------------------------
  localparam int         LIM    = 40;       // Short time limit keeps the run brief.
  localparam link_in_t   L_CFG  = 4'h8;     // Configuration request.
  localparam link_in_t   L_REQ  = 4'h4;     // Other request.
  localparam link_in_t   L_CPL  = 4'h2;     // Completion.
  localparam link_in_t   L_NP   = 4'h1;     // Outgoing non-posted request.
  localparam logic [8:0] E_DROP = 9'h060;   // Credit plus silent discard.
  localparam logic [8:0] E_DLV  = 9'h010;   // Request delivered.
  localparam logic [8:0] E_UNX  = 9'h004;   // Unexpected completion.
  localparam logic [8:0] E_GNT  = 9'h002;   // Non-posted request granted.
  localparam logic [8:0] E_DCPL = 9'h008;   // Completion delivered.
  localparam logic [8:0] E_NONE = 9'h000;   // No answer at all.
  localparam logic [8:0] E_OK   = 9'h100;   // Configuration answered with success.
  localparam logic [8:0] E_RTY  = 9'h180;   // Configuration answered with retry.

  logic        SYS_CLK = 1'b0;    // Core clock.
  logic        SRST    = 1'b1;    // Synchronous reset, held at start.
  wb_req_t     wb_req  = '0;      // Bus request driven by the bench.
  wb_rsp_t     wb_rsp;            // Bus answer.
  link_in_t    link_in;           // Packets from the partner.
  link_out_t   link_out;          // Answers to the partner.
  link_out_t   resp;              // Last answer collected.
  logic        init_done = 1'b0;  // Function-specific initialisation finished.
  logic        fn_core_reset;     // Scrub running.
  logic        ext_host_active;   // External side shows an active host.
  logic        fcr_at_ack;        // Scrub state seen at the last acknowledge.
  logic [7:0]  credits;           // Credits returned so far.
  logic [31:0] rd;                // Last read data.
  int          fails     = 0;     // Mismatches.
  int          tests_run = 0;     // Comparisons.
  int          hi_cnt    = 0;     // Cycles with the scrub running.
  int          dint_cnt  = 0;     // Interrupt deassert messages seen.
  int          n;                 // Wait loop counter.

  always #4 SYS_CLK = ~SYS_CLK;

  function_level_reset_unit #(.LIMIT_CYCLES(LIM)) function_level_reset_unit_inst
  (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
    .LINK_IN(link_in), .LINK_OUT(link_out), .INIT_DONE(init_done),
    .FN_CORE_RESET(fn_core_reset), .EXT_HOST_ACTIVE(ext_host_active)
  );

  link_partner link_partner_inst
  (
    .link_out(link_out), .sys_clk(SYS_CLK), .link_in(link_in), .credits(credits)
  );

  // Counts scrub cycles and deassert messages as they go by.
  always @(posedge SYS_CLK)
  begin
    if (fn_core_reset === 1'b1) hi_cnt++;
    if (link_out.deassert_intx === 1'b1) dint_cnt++;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // One classic bus cycle, held until the acknowledge edge, released there.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] q);
    int k;
    @(posedge SYS_CLK);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    for (k = 0; k < 20; k++)
    begin
      @(posedge SYS_CLK);
      if (wb_rsp.ack === 1'b1) break;
    end
    if (k == 20)
    begin
      fails++;
      end_sim();
    end
    q = wb_rsp.dat;
    fcr_at_ack = fn_core_reset;
    wb_req <= '0;
  endtask : wb

  // Sends one link packet through the partner and compares the whole answer.
  task automatic lnk(input string what, input link_in_t v, input logic [8:0] exp);
    link_partner_inst.fire(v, resp);
    chk(what, 32'(resp), 32'(exp));
  endtask : lnk

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    SRST <= 1'b0;
    wb(1'b0, ADR_CTRL, DATA_ZERO, rd);
    chk("ctrl after reset", rd, DATA_ZERO);
    wb(1'b0, ADR_STATUS, DATA_ZERO, rd);
    chk("status after reset", rd, 32'h0000_0008);
    wb(1'b0, 8'h20, DATA_ZERO, rd);
    chk("unmapped read", rd, DATA_ZERO);
    wb(1'b1, 8'h40, 32'h1234_5678, rd);
    wb(1'b0, 8'h40, DATA_ZERO, rd);
    chk("memory readback", rd, 32'h1234_5678);
    wb(1'b1, ADR_CTRL, 32'h0000_0007, rd);
    @(posedge SYS_CLK);
    chk("host active", 32'(ext_host_active), 32'h0000_0001);
    lnk("request delivered", L_REQ, E_DLV);
    lnk("completion unmatched", L_CPL, E_UNX);
    lnk("config answered", L_CFG, E_OK);
    lnk("request granted", L_NP, E_GNT);
    wb(1'b0, ADR_STATUS, DATA_ZERO, rd);
    chk("one pending", rd & 32'h0000_FF0F, 32'h0000_0109);
    $display("Test idle traffic done");
    // Reset is started with a request outstanding and the interrupt still up.
    wb(1'b1, ADR_CTRL, 32'h0000_8007, rd);
    chk("ack before scrub", 32'(fcr_at_ack), DATA_ZERO);
    repeat (4) @(posedge SYS_CLK);
    chk("intx deasserted", dint_cnt, 32'h0000_0001);
    chk("host hidden", 32'(ext_host_active), DATA_ZERO);
    lnk("request dropped", L_REQ, E_DROP);
    lnk("completion dropped", L_CPL, E_DROP);
    lnk("config dropped", L_CFG, E_DROP);
    chk("credits back", 32'(credits), 32'h0000_0003);
    wb(1'b0, ADR_STATUS, DATA_ZERO, rd);
    chk("scrub status", rd & 32'h0000_FF03, 32'h0000_0002);
    wb(1'b1, ADR_CTRL, 32'h0000_0002, rd);
    for (n = 0; n < 50 && fn_core_reset !== 1'b0; n++) @(posedge SYS_CLK);
    if (n == 50)
    begin
      fails++;
      end_sim();
    end
    @(posedge SYS_CLK);
    chk("scrub length", hi_cnt, 32'h0000_0010);
    lnk("config before limit", L_CFG, E_DROP);
    $display("Test scrub done");
    repeat (LIM) @(posedge SYS_CLK);
    wb(1'b0, ADR_STATUS, DATA_ZERO, rd);
    chk("limit expired", rd & 32'h0000_FF07, 32'h0000_0004);
    lnk("config retry", L_CFG, E_RTY);
    lnk("config retry again", L_CFG, E_RTY);
    @(posedge SYS_CLK) init_done <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    lnk("config ready", L_CFG, E_OK);
    @(posedge SYS_CLK) init_done <= 1'b0;
    lnk("no retry after success", L_CFG, E_OK);
    lnk("stale completion", L_CPL, E_UNX);
    wb(1'b0, 8'h40, DATA_ZERO, rd);
    chk("memory scrubbed", rd, DATA_ZERO);
    wb(1'b0, ADR_CTRL, DATA_ZERO, rd);
    chk("command cleared", rd, DATA_ZERO);
    // Re-enabled only once stale completions have been seen off.
    wb(1'b1, ADR_CTRL, 32'h0000_0002, rd);
    @(posedge SYS_CLK);
    chk("usable again", 32'(ext_host_active), 32'h0000_0001);
    $display("Test recovery done");
    // Recommended order: silence the function, drain its requests, then reset.
    wb(1'b1, ADR_CTRL, 32'h0000_0001, rd);
    lnk("second grant", L_NP, E_GNT);
    wb(1'b1, ADR_CTRL, DATA_ZERO, rd);
    lnk("grant refused", L_NP, E_NONE);
    lnk("completion delivered", L_CPL, E_DCPL);
    for (n = 0; n < 8; n++)
    begin
      wb(1'b0, ADR_STATUS, DATA_ZERO, rd);
      if (rd[ST_PENDING] == 1'b0) break;
    end
    chk("pending drained", rd & 32'h0000_FF01, DATA_ZERO);
    wb(1'b1, ADR_CTRL, 32'h0000_8000, rd);
    init_done <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    for (n = 0; n < 50 && fn_core_reset !== 1'b0; n++) @(posedge SYS_CLK);
    if (n == 50)
    begin
      fails++;
      end_sim();
    end
    chk("second scrub length", hi_cnt, 32'h0000_0020);
    chk("no intx message", dint_cnt, 32'h0000_0001);
    wb(1'b0, ADR_STATUS, DATA_ZERO, rd);
    chk("ready before limit", rd & 32'h0000_FF0F, 32'h0000_0008);
    lnk("config without retry", L_CFG, E_OK);
    $display("Test second reset done");
    end_sim();
  end

  // Cuts a hang short and reports it as a mismatch.
  initial
  begin
    #400000;
    fails++;
    end_sim();
  end
endmodule : tb_function_level_reset_unit
`default_nettype wire
